// File: verilog/sda_core.sv
`timescale 1ns/1ps
`default_nettype none
// Operation
// - In first configuration state, addresses 0x1 to 0xE are accepted.
// - Frames to address 0xF are acted on as broadcast in second configuration state; in first, only configuration-advance needs 0xF.
// - Entering first configuration, with no startup fault, both fault outputs released high.
// - Address write only in first configuration, with non-inverting input held high.
// - Address from the address-write command is stored in the address field.
// - Broadcast configuration-advance locks address and enters second configuration state.
// - Fault outputs are open-drain: pull low or release.
module sda_core
(
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    input wire logic spi_clk_in,
    input wire logic spi_cs_n_in,
    input wire logic spi_mosi_in,
    input wire logic in_plus_in,
    input wire logic startup_fault_in,
    output logic [sda_pkg::ADDR_BITS-1:0] device_address_field_out,
    output logic address_locked_out,
    output logic config1_out,
    output logic frame_accepted_out,
    output logic fault_alarm_out,
    output logic fault_alarm_oe_out,
    output logic fault_warning_out,
    output logic fault_warning_oe_out
);
    import sda_pkg::*;

    // ****************************************
    // Link domain: shift register, frame handed over by toggle
    // ****************************************
    typedef struct packed {
        logic [FRAME_BITS-1:0] shift;
        logic [FRAME_BITS-1:0] frame;
        logic toggle;
    } sda_link_s;

    sda_link_s link, next_link;
    logic [4:0] bit_count, next_bit_count;

    always_comb
    begin
        next_link = link;
        next_bit_count = bit_count + 5'h01;
        next_link.shift = {link.shift[FRAME_BITS-2:0], spi_mosi_in};
        // Frame word held stable until the next frame completes
        if (!spi_cs_n_in && bit_count == BIT_COUNT_FULL - 5'h01)
        begin
            next_link.frame = {link.shift[FRAME_BITS-2:0], spi_mosi_in};
            next_link.toggle = ~link.toggle;
        end
    end

    always_ff @(posedge spi_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            link <= '0;
        end
        else
        begin
            link <= next_link;
        end
    end

    // Select clears the count with no link edge: the clock stops between frames
    // Partial frames are dropped this way; overlong frames wrap after 32 bits
    always_ff @(posedge spi_clk_in or negedge rst_n_in or posedge spi_cs_n_in)
    begin
        if (!rst_n_in)
        begin
            bit_count <= BIT_COUNT_RESET;
        end
        else if (spi_cs_n_in)
        begin
            bit_count <= BIT_COUNT_RESET;
        end
        else
        begin
            bit_count <= next_bit_count;
        end
    end

    // ****************************************
    // Core domain
    // ****************************************
    typedef struct packed {
        logic [2:0] tog_sync;
        logic [1:0] in_sync;
        logic [1:0] flt_sync;
        sda_mode_e mode;
        logic [ADDR_BITS-1:0] addr;
        logic locked;
        logic config1;
        logic accepted;
        logic alarm_oe;
        logic warning_oe;
    } sda_core_s;

    sda_core_s st, next_st;
    sda_frame_s rx;
    logic new_frame;
    logic for_me;

    always_comb
    begin
        next_st = st;
        next_st.tog_sync = {st.tog_sync[1:0], link.toggle};
        next_st.in_sync = {st.in_sync[0], in_plus_in};
        next_st.flt_sync = {st.flt_sync[0], startup_fault_in};
        next_st.accepted = 1'b0;
        // Word is stable: toggle seen two flops late
        rx = '{addr: link.frame[ADDR_MSB:ADDR_LSB], cmd: link.frame[CMD_MSB:CMD_LSB],
               data: link.frame[DATA_MSB:DATA_LSB]};
        new_frame = st.tog_sync[2] ^ st.tog_sync[1];
        for_me = (rx.addr == ADDR_BROADCAST) || (rx.addr == st.addr);
        case (st.mode)
            SDA_IDLE:
            begin
                if (!st.flt_sync[1])
                begin
                    next_st.mode = SDA_CONFIG1;
                    next_st.config1 = 1'b1;
                    next_st.alarm_oe = 1'b0;
                    next_st.warning_oe = 1'b0;
                end
            end
            SDA_CONFIG1:
            begin
                if (new_frame)
                begin
                    if (rx.cmd == CMD_ADDRESS_WRITE && st.in_sync[1]
                        && rx.data >= ADDR_MIN && rx.data <= ADDR_MAX)
                    begin
                        next_st.addr = rx.data;
                        next_st.accepted = 1'b1;
                    end
                    else if (rx.cmd == CMD_CONFIG_ADVANCE && rx.addr == ADDR_BROADCAST)
                    begin
                        next_st.mode = SDA_CONFIG2;
                        next_st.config1 = 1'b0;
                        next_st.locked = 1'b1;
                        next_st.accepted = 1'b1;
                    end
                end
            end
            SDA_CONFIG2:
            begin
                if (new_frame && for_me)
                begin
                    next_st.accepted = 1'b1;
                end
            end
            default:
            begin
                next_st.mode = SDA_IDLE;
                next_st.config1 = 1'b0;
                next_st.locked = 1'b0;
            end
        endcase
    end

    always_ff @(posedge ref_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            st <= '{tog_sync: 3'h0, in_sync: 2'h0, flt_sync: 2'h3, mode: SDA_IDLE, addr: ADDR_NONE,
                    locked: 1'b0, config1: 1'b0, accepted: 1'b0, alarm_oe: 1'b1, warning_oe: 1'b1};
        end
        else
        begin
            st <= next_st;
        end
    end

    // Open-drain: data always low, enable pulls the line
    assign fault_alarm_out = 1'b0;
    assign fault_warning_out = 1'b0;
    assign fault_alarm_oe_out = st.alarm_oe;
    assign fault_warning_oe_out = st.warning_oe;
    assign device_address_field_out = st.addr;
    assign address_locked_out = st.locked;
    assign config1_out = st.config1;
    assign frame_accepted_out = st.accepted;

    // ****************************************
    // Checks
    // ****************************************
    sequence addr_write_seen;
        st.mode == SDA_CONFIG1 && new_frame && rx.cmd == CMD_ADDRESS_WRITE && st.in_sync[1]
            && rx.data >= ADDR_MIN && rx.data <= ADDR_MAX;
    endsequence

    addr_store_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        addr_write_seen |=> device_address_field_out == $past(rx.data))
        else $error("address not stored");
    addr_range_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        device_address_field_out == ADDR_NONE
        || (device_address_field_out >= ADDR_MIN && device_address_field_out <= ADDR_MAX))
        else $error("address out of range");
    in_plus_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        (st.mode == SDA_CONFIG1 && new_frame && !st.in_sync[1]) |=> $stable(device_address_field_out))
        else $error("address written without input high");
    lock_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        address_locked_out |=> address_locked_out && $stable(device_address_field_out))
        else $error("locked address changed");
    advance_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        (st.mode == SDA_CONFIG1 && new_frame && rx.cmd == CMD_CONFIG_ADVANCE && rx.addr == ADDR_BROADCAST)
        |=> address_locked_out)
        else $error("advance missed");
    release_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        $rose(config1_out) |-> !fault_alarm_oe_out && !fault_warning_oe_out)
        else $error("fault outputs not released");
    open_drain_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        !fault_alarm_out && !fault_warning_out
        && (config1_out || address_locked_out || (fault_alarm_oe_out && fault_warning_oe_out)))
        else $error("fault output driven high or released early");
    filter_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        (address_locked_out && new_frame && rx.addr != ADDR_BROADCAST && rx.addr != device_address_field_out)
        |=> !frame_accepted_out)
        else $error("foreign frame accepted");
    broadcast_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        (address_locked_out && new_frame && rx.addr == ADDR_BROADCAST) |=> frame_accepted_out)
        else $error("broadcast ignored");

endmodule : sda_core
`default_nettype wire

// File: common/sda_pkg.sv
package sda_pkg;

    // ****************************************
    // Frame layout (own 16-bit frame, MSB first)
    // ****************************************
    localparam int FRAME_BITS = 16;
    localparam int ADDR_BITS = 4;
    localparam int CMD_BITS = 4;
    localparam int ADDR_MSB = 15;
    localparam int ADDR_LSB = 12;
    localparam int CMD_MSB = 11;
    localparam int CMD_LSB = 8;
    localparam int DATA_MSB = 3;
    localparam int DATA_LSB = 0;

    // ****************************************
    // Addresses and commands
    // ****************************************
    localparam logic [3:0] ADDR_NONE = 4'h0;
    localparam logic [3:0] ADDR_MIN = 4'h1;
    localparam logic [3:0] ADDR_MAX = 4'he;
    localparam logic [3:0] ADDR_BROADCAST = 4'hf;
    localparam logic [3:0] CMD_ADDRESS_WRITE = 4'h1;
    localparam logic [3:0] CMD_CONFIG_ADVANCE = 4'h2;
    localparam logic [4:0] BIT_COUNT_RESET = 5'h00;
    localparam logic [4:0] BIT_COUNT_FULL = 5'h10;

    typedef enum {SDA_IDLE, SDA_CONFIG1, SDA_CONFIG2} sda_mode_e;

    typedef struct packed {
        logic [3:0] addr;
        logic [3:0] cmd;
        logic [3:0] data;
    } sda_frame_s;

endpackage : sda_pkg

// File: tb/sda_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module sda_host_model
(
    output logic spi_clk_out,
    output logic spi_cs_n_out,
    output logic spi_mosi_out
);
    initial
    begin
        spi_clk_out = 1'b0;
        spi_cs_n_out = 1'b1;
        spi_mosi_out = 1'b0;
    end

    // Link clock only runs inside a frame; 30 ns period
    task automatic send_frame(input logic [15:0] word);
        int i;
        spi_cs_n_out = 1'b0;
        for (i = 15; i >= 0; i--)
        begin
            spi_mosi_out = word[i];
            #15 spi_clk_out = 1'b1;
            #15 spi_clk_out = 1'b0;
        end
        #15 spi_cs_n_out = 1'b1;
        // Released line: no pull, so show the inverse
        spi_mosi_out = ~spi_mosi_out;
    endtask : send_frame
endmodule : sda_host_model
`default_nettype wire

// File: tb/tb_sda_core.sv
`timescale 1ns/1ps
`default_nettype none
module tb_sda_core;
    import sda_pkg::*;
    logic ref_clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic in_plus_in = 1'b0;
    logic startup_fault_in = 1'b0;
    logic spi_clk, spi_cs_n, spi_mosi;
    logic [3:0] addr;
    logic locked, config1, accepted, alarm, alarm_oe, warning, warning_oe;
    int num_errors = 0;
    int checked = 0;
    int pulses = 0;
    // ****************************************
    // Clock, open-drain lines, pulse counter
    // ****************************************
    always #50 ref_clk_in = ~ref_clk_in;
    wire alarm_line = alarm_oe ? alarm : 1'b1;
    wire warning_line = warning_oe ? warning : 1'b1;
    always @(posedge ref_clk_in) if (accepted === 1'b1) pulses <= pulses + 1;

    sda_host_model sda_host_model_i (.spi_clk_out(spi_clk), .spi_cs_n_out(spi_cs_n), .spi_mosi_out(spi_mosi));
    sda_core sda_core_i (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .spi_clk_in(spi_clk),
        .spi_cs_n_in(spi_cs_n), .spi_mosi_in(spi_mosi), .in_plus_in(in_plus_in),
        .startup_fault_in(startup_fault_in), .device_address_field_out(addr),
        .address_locked_out(locked), .config1_out(config1), .frame_accepted_out(accepted),
        .fault_alarm_out(alarm), .fault_alarm_oe_out(alarm_oe), .fault_warning_out(warning),
        .fault_warning_oe_out(warning_oe));

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : wrap_up

    task automatic check(input string name, input logic [3:0] seen, input logic [3:0] exp);
        checked++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // Frames spaced 12 core cycles, beyond the crossing's minimum
    task automatic run_frame(input logic [3:0] a, input logic [3:0] c, input logic [3:0] d, input logic [3:0] n);
        pulses = 0;
        sda_host_model_i.send_frame({a, c, 4'h0, d});
        repeat (12) @(negedge ref_clk_in);
        check("accepted pulses", pulses[3:0], n);
    endtask : run_frame

    task automatic test_startup();
        int i;
        for (i = 0; i < 20 && config1 !== 1'b1; i++) @(negedge ref_clk_in);
        check("config1", {3'h0, config1}, 4'h1);
        check("alarm line", {3'h0, alarm_line}, 4'h1);
        check("warning line", {3'h0, warning_line}, 4'h1);
        check("alarm data", {3'h0, alarm | warning}, 4'h0);
        check("address", addr, ADDR_NONE);
        $display("test_startup done");
    endtask : test_startup

    task automatic test_assign();
        run_frame(4'h0, CMD_ADDRESS_WRITE, 4'h5, 4'h0);
        check("address", addr, ADDR_NONE);
        in_plus_in = 1'b1;
        run_frame(4'h0, CMD_ADDRESS_WRITE, ADDR_BROADCAST, 4'h0);
        run_frame(4'h0, CMD_ADDRESS_WRITE, 4'h0, 4'h0);
        run_frame(4'h0, CMD_ADDRESS_WRITE, ADDR_MAX, 4'h1);
        check("address", addr, ADDR_MAX);
        run_frame(4'h0, CMD_ADDRESS_WRITE, ADDR_MIN, 4'h1);
        check("address", addr, ADDR_MIN);
        $display("test_assign done");
    endtask : test_assign

    task automatic test_lock();
        run_frame(ADDR_BROADCAST, CMD_CONFIG_ADVANCE, 4'h0, 4'h1);
        check("locked", {3'h0, locked}, 4'h1);
        check("config1", {3'h0, config1}, 4'h0);
        run_frame(4'h5, CMD_CONFIG_ADVANCE, 4'h0, 4'h0);
        run_frame(ADDR_MIN, CMD_CONFIG_ADVANCE, 4'h0, 4'h1);
        // Broadcast still acted on, but the locked address stays
        run_frame(ADDR_BROADCAST, CMD_ADDRESS_WRITE, 4'h7, 4'h1);
        check("address", addr, ADDR_MIN);
        $display("test_lock done");
    endtask : test_lock

    task automatic test_fault();
        startup_fault_in = 1'b1;
        rst_n_in = 1'b0;
        repeat (16) @(negedge ref_clk_in);
        rst_n_in = 1'b1;
        repeat (10) @(negedge ref_clk_in);
        check("config1", {3'h0, config1}, 4'h0);
        check("alarm line", {3'h0, alarm_line}, 4'h0);
        check("warning line", {3'h0, warning_line}, 4'h0);
        check("locked", {3'h0, locked}, 4'h0);
        check("address", addr, ADDR_NONE);
        $display("test_fault done");
    endtask : test_fault

    initial
    begin
        repeat (16) @(negedge ref_clk_in);
        rst_n_in = 1'b1;
        test_startup();
        test_assign();
        test_lock();
        test_fault();
        wrap_up();
    end
endmodule : tb_sda_core
`default_nettype wire
